// File: event_recorder_cfg.svh
// Offsets, field positions, reset values, codes and timing counts of the event recorder.
// Assumes inclusion by bare name from every file that needs them.
`ifndef EVENT_RECORDER_CFG_SVH
`define EVENT_RECORDER_CFG_SVH

// Register byte addresses
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_MASK        8'h08
`define REG_DATA        8'h0c
`define REG_LEVEL       8'h10
`define REG_DROPS       8'h14
`define REG_RECORDS     8'h18

// Control fields
`define CTRL_RUN        0
`define CTRL_MODE_LO    1
`define CTRL_MODE_HI    2
`define CTRL_FALL_LO    3
`define CTRL_FALL_HI    5
`define CTRL_ROUTER     6
`define CTRL_WIDTH      7
`define CTRL_RESET      7'h00

// Status and mask bits
`define ST_OVERRUN      0
`define ST_MARKER       1
`define ST_WRAP         2
`define ST_DROP         3
`define ST_WIDTH        4
`define MASK_RESET      4'h0

// Record layout
`define REC_CHAN_HI     31
`define REC_CHAN_LO     28
`define REC_SPECIAL     4'hf
`define REC_DTIME_HI    27
`define REC_DTIME_LO    16
`define TAG_WIDTH       28
`define NSYNC_WIDTH     16
`define DTIME_WIDTH     12
`define MARKERS         3

// Record buffer: 256 k records
`define FIFO_AW         18
`define FIFO_DEPTH      19'h40000

// Marker timing, counted at 40 MHz
`define CLK_PERIOD_NS   25
`define MARKER_HOLD_NS  100
`define MARKER_HOLD_CYC ((`MARKER_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: event_recorder_pkg.sv
// Types shared by the event recorder files.
// Assumes event_recorder_cfg.svh supplies the numbers.
package event_recorder_pkg;

   typedef enum logic [1:0] {
      interactive_mode        = 2'b00,
      absolute_tag_mode       = 2'b01,
      sync_relative_tag_mode  = 2'b10
   } acq_mode_t;

   typedef enum logic [3:0] {
      bus_idle  = 4'b0001,
      bus_wait  = 4'b0010,
      bus_latch = 4'b0100,
      bus_done  = 4'b1000
   } bus_state_t;

endpackage

// File: marker_edge.sv
// One marker input edge detector with selectable active edge.
// Assumes the marker level is synchronous to mclk.
`timescale 1ns/100ps
module marker_edge (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic reset,
   // Marker level and edge choice
   input  wire logic level,
   input  wire logic fall,
   // One-cycle pulse per active edge
   output logic      pulse
);

   logic prev;

   always_ff @(posedge mclk) begin
      if (reset) begin
         prev  <= 1'b0;
         pulse <= 1'b0;
      end else begin
         prev  <= level;
         pulse <= fall ? (prev & ~level) : (~prev & level);
      end
   end

endmodule

// File: record_mem.sv
// Record buffer storage: one write port, one read port with registered data.
// Assumes the caller never writes a full buffer.
`timescale 1ns/100ps
`include "event_recorder_cfg.svh"
module record_mem (
   // Clock
   input  wire logic                   mclk,
   // Write side
   input  wire logic                   wr_en,
   input  wire logic [`FIFO_AW-1:0]    wr_addr,
   input  wire logic [31:0]            wr_data,
   // Read side
   input  wire logic [`FIFO_AW-1:0]    rd_addr,
   output logic      [31:0]            rd_data
);

   logic [31:0] store [0:(1 << `FIFO_AW)-1];

   always_ff @(posedge mclk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
   end

   // Read data always from a register, one edge behind the address
   always_ff @(posedge mclk) begin
      rd_data <= store[rd_addr];
   end

endmodule

// File: marker_and_gate_event_recorder.sv
// Marker and count-gate event recorder with its record buffer and APB registers.
// Assumes marker, gate and photon inputs are synchronous to mclk and an APB master.
`timescale 1ns/100ps
`include "event_recorder_cfg.svh"
module marker_and_gate_event_recorder (
   // Clock and reset
   input  wire logic                      mclk,
   input  wire logic                      reset,
   // APB slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // Converter side
   input  wire logic                      photon_valid,
   input  wire logic [3:0]                photon_channel,
   input  wire logic [`DTIME_WIDTH-1:0]   photon_dtime,
   input  wire logic                      sync_pulse,
   // Control port pins
   input  wire logic [`MARKERS-1:0]       marker_in,
   input  wire logic                      count_enable,
   output logic                           measurement_active,
   // Interactive histogram feed
   output logic                           hist_valid,
   output logic [`DTIME_WIDTH-1:0]        hist_dtime,
   output logic [3:0]                     hist_channel,
   // Interrupt
   output logic                           irq
);

   logic [`CTRL_WIDTH-1:0]    ctrl;
   logic [`ST_WIDTH-1:0]      status;
   logic [`ST_WIDTH-1:0]      mask;
   logic [31:0]               drops;
   logic [31:0]               records;
   event_recorder_pkg::bus_state_t bus_state;
   event_recorder_pkg::acq_mode_t  mode;
   logic                      run;
   logic                      recording;
   logic                      router_attached;
   logic [`MARKERS-1:0]       edge_pulse;
   logic [`MARKERS-1:0]       marker_pend;
   logic                      wrap_pend;
   logic [`TAG_WIDTH-1:0]     tag_count;
   logic [`NSYNC_WIDTH-1:0]   nsync;
   logic                      tag_wrap;
   logic                      gate_open;
   logic                      photon_ok;
   logic                      want_marker;
   logic                      want_wrap;
   logic                      want_write;
   logic                      full;
   logic                      push;
   logic                      pop;
   logic [31:0]               next_record;
   logic [`FIFO_AW-1:0]       wr_ptr;
   logic [`FIFO_AW-1:0]       rd_ptr;
   logic [`FIFO_AW:0]         level;
   logic [31:0]               mem_q;
   logic                      have_data;
   logic                      access_done;
   logic                      bus_write;
   logic                      bus_read;
   logic [`ST_WIDTH-1:0]      events;

   assign mode = event_recorder_pkg::acq_mode_t'(ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO]);
   assign run  = ctrl[`CTRL_RUN];
   assign router_attached = ctrl[`CTRL_ROUTER];
   assign recording = run && (mode != event_recorder_pkg::interactive_mode);

   // Marker edge capture, one detector per input
   genvar gi;
   generate
      for (gi = 0; gi < `MARKERS; gi++) begin : g_marker
         marker_edge u_edge (
            .mclk  (mclk),
            .reset (reset),
            .level (marker_in[gi]),
            .fall  (ctrl[`CTRL_FALL_LO + gi]),
            .pulse (edge_pulse[gi])
         );
      end
   endgenerate

   // Count gate: a router owns the pin, so the gate is then ignored
   assign gate_open = router_attached | count_enable;
   assign photon_ok = photon_valid & gate_open & run;

   // Tag counters, restarted when a measurement is not running
   always_ff @(posedge mclk) begin
      if (reset || !recording) begin
         tag_count <= '0;
         nsync     <= '0;
      end else begin
         tag_count <= tag_count + 1'b1;
         if (sync_pulse) begin
            nsync <= nsync + 1'b1;
         end
      end
   end

   // A wrap in the counter of the active mode calls for an overflow record
   always_comb begin
      if (mode == event_recorder_pkg::sync_relative_tag_mode) begin
         tag_wrap = recording && sync_pulse && (&nsync);
      end else begin
         tag_wrap = recording && (&tag_count);
      end
   end

   // Pending markers and wrap: a new event wins over the clear of its slot
   always_ff @(posedge mclk) begin
      if (reset || !recording) begin
         marker_pend <= '0;
         wrap_pend   <= 1'b0;
      end else begin
         marker_pend <= (marker_pend & ~(push && want_marker ? marker_pend : '0))
                        | edge_pulse;
         wrap_pend   <= (wrap_pend & ~(push && !want_marker && want_wrap)) | tag_wrap;
      end
   end

   // Insertion priority: markers, then overflow, then photons
   assign want_marker = |marker_pend;
   assign want_wrap   = wrap_pend;
   assign want_write  = recording && (want_marker || want_wrap || photon_ok);
   assign full        = (level == `FIFO_DEPTH);
   assign push        = want_write && !full;

   // Record assembly; 32 bits, layout chosen by mode
   always_comb begin
      next_record = '0;
      if (mode == event_recorder_pkg::sync_relative_tag_mode) begin
         next_record[`NSYNC_WIDTH-1:0] = nsync;
         if (want_marker) begin
            next_record[`REC_CHAN_HI:`REC_CHAN_LO] = `REC_SPECIAL;
            next_record[`REC_DTIME_LO + `MARKERS - 1:`REC_DTIME_LO] = marker_pend;
         end else if (want_wrap) begin
            next_record[`REC_CHAN_HI:`REC_CHAN_LO] = `REC_SPECIAL;
         end else begin
            next_record[`REC_CHAN_HI:`REC_CHAN_LO]   = photon_channel;
            next_record[`REC_DTIME_HI:`REC_DTIME_LO] = photon_dtime;
         end
      end else begin
         next_record[`TAG_WIDTH-1:0] = tag_count;
         if (want_marker) begin
            next_record[`REC_CHAN_HI:`REC_CHAN_LO] = `REC_SPECIAL;
            next_record[`MARKERS-1:0] = marker_pend;
         end else if (want_wrap) begin
            next_record[`REC_CHAN_HI:`REC_CHAN_LO] = `REC_SPECIAL;
            next_record[`MARKERS-1:0] = '0;
         end else begin
            next_record[`REC_CHAN_HI:`REC_CHAN_LO] = photon_channel;
         end
      end
   end

   record_mem u_mem (
      .mclk    (mclk),
      .wr_en   (push),
      .wr_addr (wr_ptr),
      .wr_data (next_record),
      .rd_addr (rd_ptr),
      .rd_data (mem_q)
   );

   // Buffer pointers and fill level
   always_ff @(posedge mclk) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            level <= level + 1'b1;
         end else if (pop && !push) begin
            level <= level - 1'b1;
         end
      end
   end

   // Interactive histogram feed, gated the same way as records
   always_ff @(posedge mclk) begin
      if (reset) begin
         hist_valid   <= 1'b0;
         hist_dtime   <= '0;
         hist_channel <= '0;
      end else begin
         hist_valid   <= photon_ok && (mode == event_recorder_pkg::interactive_mode);
         hist_dtime   <= photon_dtime;
         hist_channel <= photon_channel;
      end
   end

   // Measurement active follows the run bit
   always_ff @(posedge mclk) begin
      if (reset) begin
         measurement_active <= 1'b0;
      end else begin
         measurement_active <= run;
      end
   end

   // APB access: three access cycles so the buffer read data can settle
   always_ff @(posedge mclk) begin
      if (reset) begin
         bus_state <= event_recorder_pkg::bus_idle;
      end else begin
         unique case (bus_state)
            event_recorder_pkg::bus_idle: begin
               if (psel && !penable) begin
                  bus_state <= event_recorder_pkg::bus_wait;
               end
            end
            event_recorder_pkg::bus_wait: begin
               bus_state <= event_recorder_pkg::bus_latch;
            end
            event_recorder_pkg::bus_latch: begin
               bus_state <= event_recorder_pkg::bus_done;
            end
            event_recorder_pkg::bus_done: begin
               bus_state <= event_recorder_pkg::bus_idle;
            end
            default: begin
               bus_state <= event_recorder_pkg::bus_idle;
            end
         endcase
      end
   end

   assign pready      = (bus_state == event_recorder_pkg::bus_done);
   assign pslverr     = 1'b0;
   assign access_done = pready && psel && penable;
   assign bus_write   = access_done && pwrite;
   assign bus_read    = access_done && !pwrite;
   assign pop         = bus_read && (paddr == `REG_DATA) && have_data;

   // Buffer occupancy is sampled early so the read data is already valid
   always_ff @(posedge mclk) begin
      if (reset) begin
         have_data <= 1'b0;
      end else if (bus_state == event_recorder_pkg::bus_wait) begin
         have_data <= (level != '0);
      end
   end

   // Read data registered one cycle before pready
   always_ff @(posedge mclk) begin
      if (reset) begin
         prdata <= '0;
      end else if (bus_state == event_recorder_pkg::bus_latch) begin
         case (paddr)
            `REG_CTRL:    prdata <= {{(32-`CTRL_WIDTH){1'b0}}, ctrl};
            `REG_STATUS:  prdata <= {{(32-`ST_WIDTH){1'b0}}, status};
            `REG_MASK:    prdata <= {{(32-`ST_WIDTH){1'b0}}, mask};
            `REG_DATA:    prdata <= have_data ? mem_q : 32'h00000000;
            `REG_LEVEL:   prdata <= {{(31-`FIFO_AW){1'b0}}, level};
            `REG_DROPS:   prdata <= drops;
            `REG_RECORDS: prdata <= records;
            default:      prdata <= 32'h00000000;
         endcase
      end
   end

   // Control and mask registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl <= `CTRL_RESET;
         mask <= `MASK_RESET;
      end else if (bus_write) begin
         if (paddr == `REG_CTRL) begin
            ctrl <= pwdata[`CTRL_WIDTH-1:0];
         end
         if (paddr == `REG_MASK) begin
            mask <= pwdata[`ST_WIDTH-1:0];
         end
      end
   end

   // Sticky events; a read clears, but an event in that cycle survives
   always_comb begin
      events = '0;
      events[`ST_OVERRUN] = want_write && full;
      events[`ST_MARKER]  = |edge_pulse && recording;
      events[`ST_WRAP]    = tag_wrap;
      events[`ST_DROP]    = photon_ok && recording && !(push && !want_marker && !want_wrap);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         status <= '0;
      end else if (bus_read && (paddr == `REG_STATUS)) begin
         status <= events;
      end else begin
         status <= status | events;
      end
   end

   // Counters of dropped photons and written records, restarted with a run
   always_ff @(posedge mclk) begin
      if (reset || (bus_write && (paddr == `REG_CTRL) && pwdata[`CTRL_RUN] && !run)) begin
         drops   <= '0;
         records <= '0;
      end else begin
         if (events[`ST_DROP]) begin
            drops <= drops + 1'b1;
         end
         if (push) begin
            records <= records + 1'b1;
         end
      end
   end

   assign irq = |(status & mask);

endmodule

// File: marker_and_gate_event_recorder_asserts.sv
// Port-level checks of the event recorder.
// Assumes a bind onto the recorder and a well-behaved APB master.
`timescale 1ns/100ps
`include "event_recorder_cfg.svh"
module recorder_checker (
   // Clock and reset
   input wire logic                    mclk,
   input wire logic                    reset,
   // APB
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [7:0]              paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   // Converter and pins
   input wire logic                    photon_valid,
   input wire logic [3:0]              photon_channel,
   input wire logic [`DTIME_WIDTH-1:0] photon_dtime,
   input wire logic [`MARKERS-1:0]     marker_in,
   input wire logic                    count_enable,
   input wire logic                    measurement_active,
   input wire logic                    hist_valid,
   input wire logic [`DTIME_WIDTH-1:0] hist_dtime,
   input wire logic [3:0]              hist_channel,
   input wire logic                    irq
);
   // Shadow of CTRL and MASK, rebuilt from completed writes
   logic [`CTRL_WIDTH-1:0] ctrl_q;
   logic [`ST_WIDTH-1:0]   mask_q;
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_q <= `CTRL_RESET;
         mask_q <= `MASK_RESET;
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == `REG_CTRL) begin
            ctrl_q <= pwdata[`CTRL_WIDTH-1:0];
         end
         if (paddr == `REG_MASK) begin
            mask_q <= pwdata[`ST_WIDTH-1:0];
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_no_slverr: assert property (pslverr == 1'b0)
      else $error("slave error raised");
   a_ready_wait: assert property (psel && !penable |-> ##1 !pready ##1 !pready ##1 pready)
      else $error("ready not in third access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_unmapped_zero: assert property (pready && !pwrite && paddr > `REG_RECORDS |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_hist_gated: assert property (hist_valid |-> $past(photon_valid && ctrl_q[0] &&
      ctrl_q[2:1] == 2'b00 && (count_enable || ctrl_q[6])))
      else $error("histogram photon without open gate");
   a_hist_copy: assert property (hist_valid |-> hist_dtime == $past(photon_dtime) &&
      hist_channel == $past(photon_channel))
      else $error("histogram photon fields wrong");
   a_active_copy: assert property (measurement_active == $past(ctrl_q[0]))
      else $error("measurement active does not follow run");
   a_irq_masked: assert property (mask_q == `MASK_RESET |-> !irq)
      else $error("interrupt with all sources masked");
   a_marker_irq: assert property (ctrl_q[0] && ctrl_q[2:1] != 2'b00 && mask_q[`ST_MARKER] &&
      !ctrl_q[3] && $rose(marker_in[0]) |-> ##[1:4] irq)
      else $error("marker edge raised no interrupt");
endmodule

// File: scan_source.sv
// Scan controller model: marker pulses on request and the count-enable pin.
// Assumes the bench requests a pulse only while busy is low.
`timescale 1ns/100ps
module scan_source #(
   parameter int HOLD = 4
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       reset,
   // Requests from the bench
   input  wire logic [2:0] fire,
   input  wire logic       gate_low,
   // Pins toward the recorder, and busy back to the bench
   output logic      [2:0] marker_in,
   output logic            count_enable,
   output logic            busy
);
   logic [4:0] cnt;
   assign busy = cnt != 5'h0;
   // Open pin is pulled high, so the gate drops only when asked
   assign count_enable = !gate_low;
   // Each level held HOLD cycles, 100 ns at 40 MHz
   // Pulses only on request, a line clock at a time, never per pixel
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt       <= 5'h0;
         marker_in <= 3'h0;
      end else if (cnt != 5'h0) begin
         cnt <= cnt - 5'h1;
         if (cnt == 5'(HOLD + 1)) begin
            marker_in <= 3'h0;
         end
      end else if (fire != 3'h0) begin
         cnt       <= 5'(2 * HOLD);
         marker_in <= fire;
      end
   end
endmodule

// File: tb_marker_and_gate_event_recorder.sv
// Bench for the event recorder: APB master, photon feed and scenarios.
// Assumes the scan source model drives the marker and gate pins.
`timescale 1ns/100ps
`include "event_recorder_cfg.svh"
module tb_marker_and_gate_event_recorder;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        photon_valid = 1'b0;
   logic [3:0]  photon_channel = 4'h0;
   logic [11:0] photon_dtime = 12'h000;
   logic        sync_pulse = 1'b0;
   logic [2:0]  marker_in;
   logic        count_enable;
   logic        measurement_active;
   logic        hist_valid;
   logic [11:0] hist_dtime;
   logic [3:0]  hist_channel;
   logic        irq;
   logic [2:0]  fire = 3'h0;
   logic        gate_low = 1'b0;
   logic        busy;
   logic [31:0] rd;
   int          miscompares = 0;
   int          tests_run = 0;
   int          hist_count = 0;

   always #12.5 mclk = ~mclk;
   always @(negedge mclk) if (hist_valid === 1'b1) hist_count++;

   marker_and_gate_event_recorder dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .photon_valid, .photon_channel, .photon_dtime,
      .sync_pulse, .marker_in, .count_enable, .measurement_active, .hist_valid, .hist_dtime,
      .hist_channel, .irq);
   scan_source src (.mclk, .reset, .fire, .gate_low, .marker_in, .count_enable, .busy);

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until ready is seen, then releases after that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Ready and read data are taken at the rising edge that completes the access
      @(posedge mclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge mclk);
      end
      check({31'h0, pready}, 32'h1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic shoot(input logic low, input logic [3:0] ch);
      @(posedge mclk);
      gate_low <= low;
      @(posedge mclk);
      photon_valid <= 1'b1;
      photon_channel <= ch;
      photon_dtime <= 12'h5a5;
      @(posedge mclk);
      photon_valid <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   task automatic t_reset;
      check({31'h0, measurement_active}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check(rd, 32'h0);
      end
   endtask

   // Marker pulse with a chosen edge, then one record carrying the inputs
   task automatic t_marker(input logic [1:0] mode, input logic [2:0] fall, input logic [2:0] pat);
      int n;
      logic [31:0] msk;
      n = 0;
      msk = (mode == 2'b10) ? 32'hf0070000 : 32'hf0000007;
      apb(1'b1, `REG_CTRL, {25'h0, 1'b0, fall, mode, 1'b1});
      @(posedge mclk);
      fire <= pat;
      @(posedge mclk);
      fire <= 3'h0;
      @(negedge mclk);
      while (busy === 1'b1 && n < 50) begin
         n++;
         @(negedge mclk);
      end
      repeat (4) @(posedge mclk);
      check({31'h0, measurement_active}, 32'h1);
      apb(1'b0, `REG_LEVEL, 32'h0);
      check(rd, 32'h1);
      apb(1'b0, `REG_DATA, 32'h0);
      check(rd & msk, (mode == 2'b10) ? {4'hf, 9'h0, pat, 16'h0} : {4'hf, 25'h0, pat});
      check({31'h0, irq}, 32'h0);
      apb(1'b1, `REG_CTRL, 32'h0);
      apb(1'b0, `REG_STATUS, 32'h0);
   endtask

   task automatic t_gate;
      apb(1'b1, `REG_CTRL, 32'h1);
      shoot(1'b1, 4'h2);
      check(32'(hist_count), 32'h0);
      shoot(1'b0, 4'h3);
      check(32'(hist_count), 32'h1);
      apb(1'b1, `REG_CTRL, 32'h41);
      shoot(1'b1, 4'h4);
      check(32'(hist_count), 32'h2);
      apb(1'b1, `REG_CTRL, 32'h3);
      shoot(1'b1, 4'h5);
      shoot(1'b0, 4'h6);
      apb(1'b0, `REG_LEVEL, 32'h0);
      check(rd, 32'h1);
      apb(1'b0, `REG_DATA, 32'h0);
      check(rd & 32'hf0000000, 32'h60000000);
      apb(1'b1, `REG_CTRL, 32'h0);
   endtask

   // Photon burst across a marker edge: one photon loses its slot
   task automatic t_contend;
      int marks;
      marks = 0;
      apb(1'b1, `REG_MASK, 32'ha);
      apb(1'b1, `REG_CTRL, 32'h3);
      @(posedge mclk);
      fire <= 3'h1;
      @(posedge mclk);
      fire <= 3'h0;
      photon_valid <= 1'b1;
      photon_channel <= 4'h1;
      repeat (6) @(posedge mclk);
      photon_valid <= 1'b0;
      repeat (12) @(posedge mclk);
      check({31'h0, irq}, 32'h1);
      apb(1'b0, `REG_LEVEL, 32'h0);
      check(rd, 32'h6);
      apb(1'b0, `REG_DROPS, 32'h0);
      check(rd, 32'h1);
      apb(1'b0, `REG_RECORDS, 32'h0);
      check(rd, 32'h6);
      apb(1'b0, `REG_STATUS, 32'h0);
      check(rd, 32'ha);
      // The clear lands at the edge that ends the read, so look a half cycle later
      @(negedge mclk);
      check({31'h0, irq}, 32'h0);
      apb(1'b0, `REG_STATUS, 32'h0);
      check(rd, 32'h0);
      repeat (6) begin
         apb(1'b0, `REG_DATA, 32'h0);
         if (rd[31:28] === 4'hf) marks++;
      end
      check(32'(marks), 32'h1);
      apb(1'b1, `REG_CTRL, 32'h0);
   endtask

   // Sync counter wrap in sync-relative mode yields exactly one overflow record
   task automatic t_wrap;
      apb(1'b1, `REG_MASK, 32'h4);
      apb(1'b1, `REG_CTRL, 32'h5);
      @(posedge mclk);
      sync_pulse <= 1'b1;
      repeat (65536) @(posedge mclk);
      sync_pulse <= 1'b0;
      @(posedge mclk);
      check({31'h0, irq}, 32'h1);
      apb(1'b0, `REG_LEVEL, 32'h0);
      check(rd, 32'h1);
      apb(1'b0, `REG_DATA, 32'h0);
      check(rd & 32'hf007ffff, 32'hf0000000);
      apb(1'b1, `REG_CTRL, 32'h0);
      apb(1'b0, `REG_STATUS, 32'h0);
   endtask

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      t_reset;
      t_marker(2'b01, 3'h0, 3'h5);
      t_marker(2'b01, 3'h7, 3'h7);
      t_marker(2'b10, 3'h2, 3'h2);
      t_gate;
      t_contend;
      t_wrap;
      stop_test;
   end

   // The wrap scenario alone needs 65536 cycles; the rest a few hundred
   initial begin
      repeat (90000) @(posedge mclk);
      miscompares++;
      stop_test;
   end
endmodule

bind marker_and_gate_event_recorder recorder_checker chk (.mclk, .reset, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .photon_valid, .photon_channel,
   .photon_dtime, .marker_in, .count_enable, .measurement_active, .hist_valid, .hist_dtime,
   .hist_channel, .irq);
